/* include/spp_pkg.sv */
package spp_pkg;
	localparam int ADDR_W = 3;  // eight locations
	localparam int DATA_W = 8;  // byte-wide data path
	localparam int NUM_LOC = 8;
	localparam int CLK_PERIOD_NS = 100;
	// read data must stand this long before ready falls
	localparam int RD_SETUP_NS = 22;
	localparam int RD_SETUP_CYC =
		(RD_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] LOC_RESET = 8'h00;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	typedef enum logic [2:0] {
		SPP_IDLE = 3'b000,
		SPP_RD_DRIVE = 3'b001,
		SPP_RD_READY = 3'b011,
		SPP_RD_END = 3'b010,
		SPP_WR_WAIT = 3'b110
	} spp_state_type;
endpackage : spp_pkg

/* design/spp_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// small register-output memory for the port locations
module spp_mem
	import spp_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic clock, // system clock
	input wire logic srst, // synchronous reset
	input wire logic wr_en, // write strobe
	input wire logic [AW-1:0] wr_addr, // write location
	input wire logic [DW-1:0] wr_data, // write byte
	input wire logic [AW-1:0] rd_addr, // read location
	output logic [DW-1:0] rd_data // registered read byte
);
	logic [DW-1:0] mem_q [2**AW];

	// storage with reset to a known value
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < 2**AW; i++) mem_q[i] <= DW'(LOC_RESET);
		end else if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clock) begin
		if (srst) rd_data <= DW'(LOC_RESET);
		else rd_data <= mem_q[rd_addr];
	end
endmodule : spp_mem
`default_nettype wire

/* design/spp_port.sv */
`timescale 1ns/100ps
`default_nettype none
module spp_port
	import spp_pkg::*;
#(
	parameter int RD_WAIT = RD_SETUP_CYC // cycles data stands before ready
) (
	input wire logic clock, // 10 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [ADDR_W-1:0] port_addr, // location select
	input wire logic port_strobe_n, // access strobe, low active
	input wire logic port_read_not_write, // high read, low write
	input wire logic [DATA_W-1:0] port_data_in, // data bus as seen
	output logic [DATA_W-1:0] port_data_out, // data we drive
	output logic port_data_oe, // high while we drive data
	output logic port_ready_n, // ready, low active
	output logic wr_pulse, // one pulse per accepted write
	output logic [ADDR_W-1:0] wr_addr_out, // location of that write
	output logic [DATA_W-1:0] wr_data_out // byte of that write
);
	// pin synchronisers, two stages each
	logic strb_s1_q;
	logic strb_s2_q;
	logic strb_s3_q; // edge-detect stage
	logic rnw_s1_q;
	logic rnw_s2_q;
	logic [ADDR_W-1:0] addr_s1_q;
	logic [ADDR_W-1:0] addr_s2_q;
	logic [DATA_W-1:0] data_s1_q;
	logic [DATA_W-1:0] data_s2_q;

	// strobe idles high after reset, so no false edge follows it
	always_ff @(posedge clock) begin
		if (srst) begin
			strb_s1_q <= 1'b1;
			strb_s2_q <= 1'b1;
			strb_s3_q <= 1'b1;
		end else begin
			strb_s1_q <= port_strobe_n;
			strb_s2_q <= strb_s1_q;
			strb_s3_q <= strb_s2_q;
		end
	end
	// direction synchroniser
	always_ff @(posedge clock) begin
		rnw_s1_q <= port_read_not_write;
		rnw_s2_q <= rnw_s1_q;
	end

	// address synchroniser
	always_ff @(posedge clock) begin
		addr_s1_q <= port_addr;
		addr_s2_q <= addr_s1_q;
	end

	// data synchroniser; its copy ages in step with the strobe copy,
	// so the byte taken at the seen rise is the one held at the pin rise
	always_ff @(posedge clock) begin
		data_s1_q <= port_data_in;
		data_s2_q <= data_s1_q;
	end

	// falling edge between an older and a newer sample
	function automatic logic fell_between(
		input logic older,
		input logic newer
	);
		return older & ~newer;
	endfunction : fell_between

	// rising edge between an older and a newer sample
	function automatic logic rose_between(
		input logic older,
		input logic newer
	);
		return ~older & newer;
	endfunction : rose_between

	// states in which the device owns the data bus
	function automatic logic owns_bus(input spp_state_type st);
		return (st == SPP_RD_DRIVE) || (st == SPP_RD_READY);
	endfunction : owns_bus

	// strobe edges from synchronised copies only
	wire strobe_fall = fell_between(strb_s3_q, strb_s2_q);
	wire strobe_rise = rose_between(strb_s3_q, strb_s2_q);
	wire is_read = rnw_s2_q;

	spp_state_type state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] mem_rd;
	logic wr_go;

	// read wait count has run out; the memory word
	// has landed and is loaded into the pin register on the next edge
	wire rd_wait_done = (cnt_q == CNT_ZERO);

	// sequencer next state
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			SPP_IDLE: begin
				if (strobe_fall && is_read) begin
					state_d = SPP_RD_DRIVE;
					cnt_d = 4'(RD_WAIT);
				end else if (strobe_fall) begin
					state_d = SPP_WR_WAIT;
				end
			end
			SPP_RD_DRIVE: begin
				// memory read lands, then data stands
				if (rd_wait_done) state_d = SPP_RD_READY;
				else cnt_d = cnt_q - CNT_ONE;
			end
			SPP_RD_READY: begin
				if (strobe_rise) state_d = SPP_RD_END;
			end
			SPP_RD_END: state_d = SPP_IDLE;
			SPP_WR_WAIT: begin
				if (strobe_rise) state_d = SPP_IDLE;
			end
			default: state_d = SPP_IDLE;
		endcase
	end

	// capture on strobe rise in a write
	assign wr_go = (state_q == SPP_WR_WAIT) && strobe_rise;

	// sequencer state register
	always_ff @(posedge clock) begin
		if (srst) state_q <= SPP_IDLE;
		else state_q <= state_d;
	end

	// read wait counter, loaded as a read is seen
	// and counted down while the data settles
	always_ff @(posedge clock) begin
		if (srst) cnt_q <= CNT_ZERO;
		else cnt_q <= cnt_d;
	end

	// location latched as the strobe is seen falling,
	// held for the whole access
	always_ff @(posedge clock) begin
		if (srst) addr_q <= '0;
		else if (strobe_fall) addr_q <= addr_s2_q;
	end

	// location store; the read word lands one cycle
	// after addr_q, writes land at the seen strobe rise
	spp_mem u_mem (
		.clock(clock),
		.srst(srst),
		.wr_en(wr_go),
		.wr_addr(addr_q),
		.wr_data(data_s2_q),
		.rd_addr(addr_q),
		.rd_data(mem_rd)
	);

	// device owns the bus from SPP_RD_DRIVE through SPP_RD_READY
	wire drive_d = owns_bus(state_d);
	// ready low once read data has stood a full cycle on the pins,
	// or while a write is held open; high inserts waits
	wire ready_d = (state_q == SPP_RD_READY) || (state_d == SPP_WR_WAIT);

	// bus enable register; off again once the rise is seen,
	// well inside the master's gap before a write
	always_ff @(posedge clock) begin
		if (srst) port_data_oe <= 1'b0;
		else port_data_oe <= drive_d;
	end

	// read byte register, loaded while the wait count runs,
	// so it stands a cycle before ready falls
	always_ff @(posedge clock) begin
		if (srst) port_data_out <= '0;
		else if (state_q == SPP_RD_DRIVE) port_data_out <= mem_rd;
	end

	// ready register, high inserts wait states
	always_ff @(posedge clock) begin
		if (srst) port_ready_n <= 1'b1;
		else port_ready_n <= ~ready_d;
	end

	// write report: one pulse plus the location and byte taken,
	// both held until the next write
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_pulse <= 1'b0;
			wr_addr_out <= '0;
			wr_data_out <= '0;
		end else begin
			wr_pulse <= wr_go;
			if (wr_go) begin
				wr_addr_out <= addr_q;
				wr_data_out <= data_s2_q;
			end
		end
	end
endmodule : spp_port
`default_nettype wire

/* verif/spp_port_props.sv */
`timescale 1ns/100ps
`default_nettype none
// timing checks on the slave port
module spp_port_props #(parameter int RD_WAIT = 1) (
	input wire logic clock, // clk
	input wire logic srst, // rst
	input wire logic port_strobe_n, // in
	input wire logic port_read_not_write, // in
	input wire logic port_data_oe, // out
	input wire logic port_ready_n, // out
	input wire logic wr_pulse // out
);
	localparam int RLO = RD_WAIT + 3;
	localparam int RHI = RD_WAIT + 7;
	wire s = port_strobe_n;
	wire rw = port_read_not_write;
	wire oe = port_data_oe;
	wire rd = port_ready_n;
	wire wp = wr_pulse;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// read handshake
	rd_wait_a: assert property ($fell(s) && rw |-> rd [*5])
		else $error("ready too early");
	rd_ready_a: assert property ($fell(s) && rw |-> ##[RLO:RHI] !rd)
		else $error("ready late");
	data_first_a: assert property ($fell(rd) && rw |-> $past(oe, 2))
		else $error("data late");
	rd_drive_a: assert property (oe |-> rw)
		else $error("drive on write");
	// write capture, and outputs idle at reset release
	wr_float_a: assert property (!rw && !s |-> !oe)
		else $error("bus driven");
	wr_catch_a: assert property ($rose(s) && !rw |-> ##[2:5] wp)
		else $error("no capture");
	wr_one_a: assert property (wp |=> !wp)
		else $error("long pulse");
	rst_idle_a: assert property ($fell(srst) |-> rd && !oe && !wp)
		else $error("not idle");
	// main scenarios
	cover property ($fell(rd) && rw);
	cover property (wp);
	cover property ($fell(srst));
endmodule : spp_port_props
`default_nettype wire

/* verif/spp_master.sv */
`timescale 1ns/100ps
`default_nettype none
// processor side model: one access at a time
module spp_master (
	input wire logic clock, // clk
	input wire logic [7:0] port_data_out, // dev byte
	input wire logic port_data_oe, // dev drives
	input wire logic port_ready_n, // dev ready
	output var logic [2:0] port_addr, // location
	output var logic port_strobe_n, // strobe
	output var logic port_read_not_write, // direction
	output logic [7:0] port_data_in // bus level
);
	logic drv = 1'h0;
	logic [7:0] wd = 8'h00;
	// released bus shows the inverse of the last master byte
	assign port_data_in = port_data_oe ? port_data_out : drv ? wd : ~wd;
	initial begin
		port_strobe_n = 1'h1;
		port_read_not_write = 1'h1;
		port_addr = 3'h0;
	end
	// one access; reads stretch until ready
	task automatic xfer(input logic rd, input logic [2:0] a,
		input logic [7:0] w, output logic [7:0] r, output logic ok);
		int n;
		@(negedge clock);
		port_read_not_write = rd;
		port_addr = a;
		wd = w;
		drv = !rd;
		@(negedge clock);
		port_strobe_n = 1'h0;
		n = 0;
		// ready looked at on falling edges, where it has settled
		do begin
			@(negedge clock);
			n++;
		end while (port_ready_n !== 1'h0 && n < 40);
		r = port_data_in;
		ok = (port_ready_n === 1'h0);
		port_strobe_n = 1'h1;
		repeat (8) @(negedge clock);
		drv = 1'h0;
	endtask : xfer
endmodule : spp_master
`default_nettype wire

/* verif/spp_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// bench: master model against the slave port
module spp_port_tb_top;
	import spp_pkg::*;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic port_strobe_n, port_read_not_write, port_data_oe;
	logic port_ready_n, wr_pulse;
	logic [2:0] port_addr, wr_addr_out;
	logic [7:0] port_data_in, port_data_out, wr_data_out, r;
	int err_total = 0;
	int comparisons = 0;
	// 100 ns clock
	always #50 clock = ~clock;
	spp_master u_spp_master (.clock, .port_data_out, .port_data_oe,
		.port_ready_n, .port_addr, .port_strobe_n, .port_read_not_write,
		.port_data_in);
	spp_port u_spp_port (.clock, .srst, .port_addr, .port_strobe_n,
		.port_read_not_write, .port_data_in, .port_data_out, .port_data_oe,
		.port_ready_n, .wr_pulse, .wr_addr_out, .wr_data_out);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compares %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	// one access, stop on a hang
	task automatic acc(input logic rd, input logic [2:0] a,
		input logic [7:0] w);
		logic ok;
		u_spp_master.xfer(rd, a, w, r, ok);
		if (!ok) begin
			err_total++;
			$display("BAD %0t no ready", $time);
			report_and_stop();
		end
	endtask : acc
	// fresh locations read as cleared
	task automatic t_reset();
		for (int a = 0; a < NUM_LOC; a++) begin
			acc(1'h1, a[2:0], 8'h00);
			chk(r, LOC_RESET);
		end
		$display("t_reset done");
	endtask : t_reset
	// write then read straight back, then read all back again
	task automatic t_rw();
		for (int a = 0; a < 16; a++) begin
			if (a < 8) acc(1'h0, a[2:0], {a[2:0], 5'h1A} ^ a[7:0]);
			if (a < 8) chk(wr_data_out, {a[2:0], 5'h1A} ^ a[7:0]);
			if (a < 8) chk({5'h00, wr_addr_out}, a[7:0]);
			acc(1'h1, a[2:0], 8'h00);
			chk(r, {a[2:0], 5'h1A} ^ {5'h00, a[2:0]});
		end
		$display("t_rw done");
	endtask : t_rw
	initial begin
		repeat (20) @(negedge clock);
		srst = 1'h0;
		t_reset();
		t_rw();
		report_and_stop();
	end
endmodule : spp_port_tb_top
bind spp_port spp_port_props #(.RD_WAIT(RD_WAIT)) u_props (.clock, .srst,
	.port_strobe_n, .port_read_not_write, .port_data_oe, .port_ready_n,
	.wr_pulse);
`default_nettype wire
